// *** include/spdo_pkg.sv ***
// Constants, register map and types for the special pattern output stage
//
// Functional notes
// - Compare match loads programmed pattern level per output
// - Error interrupt only with error output enable set
// - Dead time inserted at falls when enabled
// - Positive fall uses value 1, negative value 0
// - Outputs 0 and 7 follow pattern directly
// - Complementary outputs never active together with dead time enabled
// - Simultaneous sets: positive wins, negative pending, error
// - Negative fall starts dead time gating positive set
// - Set during dead time waits for count end
// - Positive clear discards pending negative set
// - Simultaneous sets while negative active: positive stays off
// - Pairs 3/4 and 5/6 behave like 1/2
// - Pair select enables detection, flag and interrupt
// - Without dead time, error follows actual overlap
// - With dead time, one-clock error pulse after set
// - Detection ignores output enables; clear pair select
// - Compare values apply at reload after compare 1
// - Pattern words apply only at reload timing
// - Software output selects six fixed patterns
// - Software output control entry is immediate
// - Software output control exit waits for reload
// - Each output takes one nibble of patterns
// - Dead time counts operation clock periods
package spdo_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_IOC  = 8'h04;
  localparam logic [7:0] ADR_CMP0 = 8'h08;
  localparam logic [7:0] ADR_CMP1 = 8'h0c;
  localparam logic [7:0] ADR_CMP2 = 8'h10;
  localparam logic [7:0] ADR_CMP3 = 8'h14;
  localparam logic [7:0] ADR_PAT0 = 8'h18;
  localparam logic [7:0] ADR_PAT1 = 8'h1c;
  localparam logic [7:0] ADR_DT0  = 8'h20;
  localparam logic [7:0] ADR_DT1  = 8'h24;
  localparam logic [7:0] ADR_STAT = 8'h28;

  // ----------------------------------------------------------------
  // Control, I/O control and status field positions
  // ----------------------------------------------------------------
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_MSB = 4;
  localparam int CTL_DTE      = 5;
  localparam int CTL_EOC      = 6;
  localparam int CTL_TBA_LSB  = 7;
  localparam int CTL_TBA_MSB  = 9;
  localparam int CTL_SOC      = 10;
  localparam int CTL_CODE_LSB = 11;
  localparam int CTL_CODE_MSB = 13;
  localparam int CTL_IDC      = 14;
  localparam int CTL_THIN_LSB = 15;
  localparam int CTL_THIN_MSB = 17;
  localparam int IOC_LVL_LSB  = 8;
  localparam int STAT_FLAG    = 0;
  localparam int STAT_SW      = 1;
  localparam int STAT_CNT_LSB = 16;

  // Timer mode code for special pattern output
  localparam logic [4:0] MODE_SPECIAL = 5'h0c;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } spdo_req_t;

  typedef struct packed {
    logic [17:0]      ctrl;
    logic [15:0]      ioc;
    logic [3:0][15:0] cmp_buf;
    logic [3:0][15:0] cmp_act;
    logic [31:0]      pat_buf;
    logic [31:0]      pat_act;
    logic [15:0]      dt0;
    logic [15:0]      dt1;
    logic [15:0]      cnt;
    logic [7:0]       act;
    logic [7:0]       pins;
    logic [2:0]       wpos;
    logic [2:0]       wneg;
    logic [2:0]       gpos;
    logic [2:0][15:0] dtc;
    logic [5:0]       sw_lvl;
    logic             sw;
    logic             rl_pend;
    logic             err;
    logic             flag;
    logic [2:0]       thin_cnt;
    logic [31:0]      rdata;
  } spdo_state_t;

  localparam spdo_state_t ST_RESET = '0;

endpackage : spdo_pkg

// *** core/spdo_core.sv ***
// Special pattern output stage with dead time, interlock and error detection
`timescale 1ns/1ps
`default_nettype none
module spdo_core
  import spdo_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire spdo_req_t   req_i,
  output logic [31:0]      rdata_o,
  // Timer outputs and error interrupt
  output logic [7:0]       timer_output_o,
  output logic             error_interrupt_o
);

  // ----------------------------------------------------------------
  // State and decode helpers
  // ----------------------------------------------------------------
  spdo_state_t st;
  spdo_state_t next_st;
  logic        running;
  logic        dte;
  logic        peak;
  logic        reload;
  logic [3:0]  match;
  logic [7:0]  has;
  logic [7:0]  des;
  logic [2:0]  simul;
  logic [2:0]  gate_p;

  // Fixed six-step pattern for outputs 6..1; code 000 and 111 hold
  function automatic logic [6:0] sw_pattern(input logic [2:0] code, input logic dir);
    logic [5:0] p;
    logic       ok;
    p  = 6'h00;
    ok = 1'b1;
    case (code)
      3'h5: p = 6'h19;
      3'h4: p = 6'h29;
      3'h6: p = 6'h25;
      3'h2: p = 6'h26;
      3'h3: p = 6'h16;
      3'h1: p = 6'h1a;
      default: ok = 1'b0;
    endcase
    return {ok, dir ? ~p : p};
  endfunction : sw_pattern

  assign running = st.ctrl[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_SPECIAL;
  assign dte     = st.ctrl[CTL_DTE];
  assign peak    = running && (st.cnt == st.cmp_act[0]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       sp;
    logic       sn;
    logic       cp;
    logic       cn;
    logic       wp;
    logic       wn;
    logic       pos_n;
    logic       neg_n;
    logic       busy;
    logic       gn;
    logic [6:0] swp;
    logic       both;
    int         ip;
    int         in;
    sp = 1'b0; sn = 1'b0; cp = 1'b0; cn = 1'b0;
    wp = 1'b0; wn = 1'b0; pos_n = 1'b0; neg_n = 1'b0;
    busy = 1'b0; gn = 1'b0; swp = 7'h00; both = 1'b0;
    ip = 0; in = 0;
    next_st = st;
    simul   = 3'h0;
    gate_p  = 3'h0;
    reload  = 1'b0;

    // Register writes; compare 1 write arms the next reload
    if (req_i.wr) begin
      case (req_i.addr)
        ADR_CTRL: next_st.ctrl = req_i.wdata[17:0];
        ADR_IOC:  next_st.ioc = req_i.wdata[15:0];
        ADR_CMP0: next_st.cmp_buf[0] = req_i.wdata[15:0];
        ADR_CMP1: begin
          next_st.cmp_buf[1] = req_i.wdata[15:0];
          next_st.rl_pend    = 1'b1;
        end
        ADR_CMP2: next_st.cmp_buf[2] = req_i.wdata[15:0];
        ADR_CMP3: next_st.cmp_buf[3] = req_i.wdata[15:0];
        ADR_PAT0: next_st.pat_buf[15:0] = req_i.wdata[15:0];
        ADR_PAT1: next_st.pat_buf[31:16] = req_i.wdata[15:0];
        ADR_DT0:  next_st.dt0 = req_i.wdata[15:0];
        ADR_DT1:  next_st.dt1 = req_i.wdata[15:0];
        default: ;
      endcase
    end

    // Counter runs 0..compare 0 then wraps to zero
    next_st.cnt = !running ? 16'h0000 : (peak ? 16'h0000 : st.cnt + 16'h0001);

    // Reload at a peak once armed, thinned by the programmed count
    if (peak) begin
      if (st.thin_cnt == st.ctrl[CTL_THIN_MSB:CTL_THIN_LSB]) begin
        next_st.thin_cnt = 3'h0;
        reload = st.rl_pend;
      end else begin
        next_st.thin_cnt = st.thin_cnt + 3'h1;
      end
    end
    if (reload) begin
      next_st.cmp_act = st.cmp_buf;
      next_st.pat_act = st.pat_buf;
      next_st.rl_pend = req_i.wr && (req_i.addr == ADR_CMP1);
    end

    // Match decode: nibble bit k is the level after match k
    for (int k = 0; k < 4; k++) begin
      match[k] = running && (st.cnt == st.cmp_act[k]);
    end
    for (int i = 0; i < 8; i++) begin
      has[i] = 1'b0;
      des[i] = 1'b0;
      for (int k = 0; k < 4; k++) begin
        if (match[k]) begin
          has[i] = 1'b1;
          des[i] = st.pat_act[4*i+k];
        end
      end
      if (has[i]) begin
        next_st.act[i] = des[i];
      end
    end

    // Complementary pairs; with dead time off they follow the pattern
    for (int p = 0; p < 3; p++) begin
      ip = 2 * p + 1;
      in = 2 * p + 2;
      sp = has[ip] && des[ip];
      sn = has[in] && des[in];
      cp = has[ip] && !des[ip];
      cn = has[in] && !des[in];
      simul[p] = sp && sn && st.ctrl[CTL_TBA_LSB+p];
      both = both || (st.act[ip] && st.act[in] && st.ctrl[CTL_TBA_LSB+p]);
      if (dte) begin
        busy  = st.dtc[p] != 16'h0000;
        wp    = st.wpos[p] || sp;
        wn    = st.wneg[p] || sn;
        pos_n = st.act[ip];
        neg_n = st.act[in];
        // A positive set seen while the negative partner is on is dropped
        // A partner that clears in this very cycle is a handover, not a conflict
        if (sp && st.act[in] && !cn) begin
          wp = 1'b0;
        end
        if (cp) begin
          pos_n = 1'b0;
          wp    = 1'b0;
          if (st.wneg[p]) begin
            wn = sn;
          end
        end
        if (cn) begin
          neg_n = 1'b0;
          wn    = 1'b0;
        end
        // Gate a set already in the cycle of the partner's fall
        gate_p[p] = (busy && st.gpos[p]) || (cn && st.act[in] && st.dt0 != 16'h0000);
        gn = (busy && !st.gpos[p]) || (cp && st.act[ip] && st.dt1 != 16'h0000);
        // Positive side first, so it wins a simultaneous set
        if (wp && !neg_n && !gate_p[p]) begin
          pos_n = 1'b1;
          wp    = 1'b0;
        end
        if (wn && !pos_n && !gn) begin
          neg_n = 1'b1;
          wn    = 1'b0;
        end
        // Dead time load on each fall, then count down
        if (st.act[in] && !neg_n) begin
          next_st.dtc[p]  = st.dt0;
          next_st.gpos[p] = 1'b1;
        end else if (st.act[ip] && !pos_n) begin
          next_st.dtc[p]  = st.dt1;
          next_st.gpos[p] = 1'b0;
        end else if (busy) begin
          next_st.dtc[p] = st.dtc[p] - 16'h0001;
        end
        next_st.wpos[p] = wp;
        next_st.wneg[p] = wn;
        next_st.act[ip] = pos_n;
        next_st.act[in] = neg_n;
      end else begin
        next_st.wpos[p] = 1'b0;
        next_st.wneg[p] = 1'b0;
        next_st.dtc[p]  = 16'h0000;
      end
    end

    // Software output control overrides outputs 1..6
    swp = sw_pattern(st.ctrl[CTL_CODE_MSB:CTL_CODE_LSB], st.ctrl[CTL_IDC]);
    if (st.ctrl[CTL_SOC]) begin
      next_st.sw = 1'b1;
    end else if (reload) begin
      next_st.sw = 1'b0;
    end
    if (next_st.sw && swp[6]) begin
      next_st.sw_lvl = swp[5:0];
    end
    if (next_st.sw) begin
      next_st.act[6:1] = next_st.sw_lvl;
    end

    // Stopped timer parks every output inactive
    if (!running) begin
      next_st.act  = 8'h00;
      next_st.wpos = 3'h0;
      next_st.wneg = 3'h0;
      next_st.dtc  = '0;
    end

    // Error: pulse on simultaneous sets, or level on real overlap.
    // Detection uses internal levels, so disabled pins still report.
    next_st.err = st.ctrl[CTL_EOC] && (dte ? |simul : both);
    if ((dte && |simul) || (!dte && both)) begin
      next_st.flag = 1'b1;
    end else if (req_i.wr && req_i.addr == ADR_STAT && req_i.wdata[STAT_FLAG]) begin
      next_st.flag = 1'b0;
    end

    // Pin drive: disabled pins sit at their inactive level
    for (int i = 0; i < 8; i++) begin
      next_st.pins[i] = st.ioc[i] ? (next_st.act[i] ^ st.ioc[IOC_LVL_LSB+i])
                                  : st.ioc[IOC_LVL_LSB+i];
    end

    // Read data stands only in the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (req_i.rd) begin
      case (req_i.addr)
        ADR_CTRL: next_st.rdata = {14'h0000, st.ctrl};
        ADR_IOC:  next_st.rdata = {16'h0000, st.ioc};
        ADR_CMP0: next_st.rdata = {16'h0000, st.cmp_buf[0]};
        ADR_CMP1: next_st.rdata = {16'h0000, st.cmp_buf[1]};
        ADR_CMP2: next_st.rdata = {16'h0000, st.cmp_buf[2]};
        ADR_CMP3: next_st.rdata = {16'h0000, st.cmp_buf[3]};
        ADR_PAT0: next_st.rdata = {16'h0000, st.pat_buf[15:0]};
        ADR_PAT1: next_st.rdata = {16'h0000, st.pat_buf[31:16]};
        ADR_DT0:  next_st.rdata = {16'h0000, st.dt0};
        ADR_DT1:  next_st.rdata = {16'h0000, st.dt1};
        ADR_STAT: next_st.rdata = {st.cnt, 14'h0000, st.sw, st.flag};
        default:  next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register; reset leaves every pin low and inactive
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o           = st.rdata;
  assign timer_output_o    = st.pins;
  assign error_interrupt_o = st.err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_peak;
    running && st.cnt == st.cmp_act[0];
  endsequence

  sequence s_neg_fall;
    dte && running && !st.sw && $fell(st.act[2]) && st.dt0 >= 16'h0002;
  endsequence

  cnt_wrap_a: assert property (s_peak |=> st.cnt == 16'h0000)
    else $error("counter did not wrap at compare 0");
  out_follow_a: assert property (has[0] |=> st.act[0] == $past(des[0]))
    else $error("output 0 did not follow its pattern");
  err_gate_a: assert property (!st.ctrl[CTL_EOC] |=> !st.err)
    else $error("error interrupt without enable");
  err_pulse_a: assert property (dte && st.ctrl[CTL_EOC] && |simul |=> st.err && st.flag)
    else $error("no error pulse after simultaneous sets");
  dt_gap_a: assert property (s_neg_fall |-> !st.act[1] ##1 !st.act[1])
    else $error("positive output rose inside dead time");
  sw_entry_a: assert property (st.ctrl[CTL_SOC] |=> st.sw)
    else $error("software output entry delayed");
  sw_exit_a: assert property (st.sw && !st.ctrl[CTL_SOC] && !reload |=> st.sw)
    else $error("software output left before reload");
  pat_hold_a: assert property (!reload |=> $stable(st.pat_act) && $stable(st.cmp_act))
    else $error("pattern or compare changed outside reload");

  generate
    for (genvar g = 0; g < 3; g++) begin : g_pair
      pair_lock_a: assert property (dte && !st.sw |-> !(st.act[2*g+1] && st.act[2*g+2]))
        else $error("complementary outputs active together");
      prio_set_a: assert property (dte && !st.sw && simul[g] && !st.act[2*g+2] && !gate_p[g]
                                   |=> st.act[2*g+1])
        else $error("positive output lost simultaneous set");
    end
  endgenerate

endmodule : spdo_core
`default_nettype wire

// *** bench/spdo_gate_model.sv ***
// Gate driver model for the three complementary switch pairs
`timescale 1ns/1ps
`default_nettype none
module spdo_gate_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Gate drive lines from the timer, active high with level bits at 0
  input  wire logic [7:0] gate_i,
  // Cycles in which both switches of some leg conducted
  output int              shoot_cnt
);
  // ----------------------------------------------------------------
  // Shoot-through watch
  // ----------------------------------------------------------------
  // A leg with both switches on shorts the supply, so every such cycle counts
  initial shoot_cnt = 0;
  always @(posedge sys_clk_i) begin
    if ((gate_i[1] & gate_i[2]) | (gate_i[3] & gate_i[4]) | (gate_i[5] & gate_i[6])) begin
      shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule : spdo_gate_model
`default_nettype wire

// *** bench/spdo_core_tb.sv ***
// Self-checking testbench for the special pattern output stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module spdo_core_tb import spdo_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and settings
  // ----------------------------------------------------------------
  localparam int PER = 20;
  localparam int CP1 = 3;
  localparam int CP2 = 8;
  localparam int DT0 = 2;
  localparam int DT1 = 5;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  spdo_req_t   req       = '0;
  logic [31:0] rdata_o;
  logic [7:0]  timer_output_o;
  logic        error_interrupt_o;
  wire  [8:0]  obs = {error_interrupt_o, timer_output_o};
  logic [31:0] d;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          shoot_cnt;
  int          w;
  logic [14:0] sw_tab [3] = '{15'h2_819, 15'h6_826, 15'h1_026};

  // Clock at 125 MHz
  always #4 sys_clk_i = ~sys_clk_i;

  spdo_core uut (
    .sys_clk_i         (sys_clk_i),
    .rst_n_i           (rst_n_i),
    .req_i             (req),
    .rdata_o           (rdata_o),
    .timer_output_o    (timer_output_o),
    .error_interrupt_o (error_interrupt_o)
  );

  spdo_gate_model gates (
    .sys_clk_i (sys_clk_i),
    .gate_i    (timer_output_o),
    .shoot_cnt (shoot_cnt)
  );

  // ----------------------------------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= v;
    @(posedge sys_clk_i);
    req.wr    <= 1'b0;
    // Step off the edge so callers never sample outputs as they launch
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk_i);
    req.rd   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  // Sample one step after the edge so the edge's updates have landed
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic wait_lvl(input int i, input logic v);
    int n;
    n = 0;
    while (obs[i] !== v && n < 300) begin
      tick();
      n++;
    end
  endtask : wait_lvl

  // Length of one whole high pulse, so a pulse already running is skipped
  task automatic width(input int i, output int n);
    n = 0;
    wait_lvl(i, 1'b0);
    wait_lvl(i, 1'b1);
    while (obs[i] === 1'b1 && n < 300) begin
      tick();
      n++;
    end
  endtask : width

  // Cycles from the fall of one line to the rise of another
  task automatic gap(input int a, input int b, output int n);
    n = 0;
    wait_lvl(a, 1'b1);
    wait_lvl(a, 1'b0);
    while (obs[b] !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
  endtask : gap

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, far beyond the several hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(ADR_CTRL, d);
    `CHK("ctrl reset", 32'h0000_0000, d)
    `CHK("pins reset", 8'h00, timer_output_o)
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, d);
    `CHK("unmapped", 32'h0000_0000, d)
    // Period 20, pair 1/2 and 3/4 hand over at compare 2, pair 5/6 set together
    wr(ADR_IOC, 32'h0000_00ff);
    wr(ADR_CMP0, 32'(PER - 1));
    wr(ADR_CMP2, 32'(CP2));
    wr(ADR_CMP3, 32'h0000_0010);
    wr(ADR_PAT0, 32'h0000_4421);
    wr(ADR_PAT1, 32'h0000_2222);
    wr(ADR_DT0, 32'(DT0));
    wr(ADR_DT1, 32'(DT1));
    wr(ADR_CTRL, 32'h0000_026c);
    wr(ADR_CMP1, 32'(CP1));
    width(0, w);
    `CHK("out0 width", CP1 + 1, w)
    width(7, w);
    `CHK("out7 width", CP2 - CP1, w)
    gap(1, 2, w);
    `CHK("dead 1 to 2", 1, int'(w >= DT1 && w <= DT1 + 1))
    gap(4, 3, w);
    `CHK("dead 4 to 3", 1, int'(w >= DT0 && w <= DT0 + 1))
    width(8, w);
    `CHK("error pulse", 1, w)
    rd(ADR_STAT, d);
    `CHK("flag", 1'b1, d[STAT_FLAG])
    w = 0;
    repeat (2 * PER) begin
      tick();
      if (timer_output_o[6] !== 1'b0 || timer_output_o[5] !== 1'b1 && obs[6]) w++;
    end
    `CHK("out6 dropped", 0, w)
    `CHK("shoot", 0, shoot_cnt)
    // Error output off and gates disabled: no interrupt, flag still set
    wr(ADR_STAT, 32'h0000_0001);
    wr(ADR_IOC, 32'h0000_009f);
    wr(ADR_CTRL, 32'h0000_022c);
    w = 0;
    repeat (2 * PER) begin
      tick();
      if (error_interrupt_o !== 1'b0) w++;
    end
    `CHK("error masked", 0, w)
    rd(ADR_STAT, d);
    `CHK("flag masked", 1'b1, d[STAT_FLAG])
    wr(ADR_IOC, 32'h0000_00ff);
    wr(ADR_CTRL, 32'h0000_024c);
    width(8, w);
    `CHK("error level", CP2 - CP1, w)
    // New compare 2 and pattern wait for the compare 1 write
    wr(ADR_CMP2, 32'h0000_000a);
    wr(ADR_PAT0, 32'h0000_4423);
    width(7, w);
    `CHK("cmp held", CP2 - CP1, w)
    width(0, w);
    `CHK("pat held", CP1 + 1, w)
    wr(ADR_CMP1, 32'(CP1));
    repeat (2 * PER) tick();
    width(7, w);
    `CHK("cmp new", 10 - CP1, w)
    width(0, w);
    `CHK("pat new", 11, w)
    // Software patterns: direction, code and expected outputs 6..1
    foreach (sw_tab[i]) begin
      wr(ADR_CTRL, 32'h0000_040c | (32'(sw_tab[i][14:11]) << 11));
      repeat (3) tick();
      `CHK("sw pattern", sw_tab[i][5:0], timer_output_o[6:1])
    end
    // No pair selected now, so a write of one must clear the flag
    wr(ADR_STAT, 32'h0000_0001);
    rd(ADR_STAT, d);
    `CHK("flag clear", 1'b0, d[STAT_FLAG])
    wr(ADR_CTRL, 32'h0000_000c);
    repeat (2 * PER) tick();
    rd(ADR_STAT, d);
    `CHK("sw held", 1'b1, d[STAT_SW])
    wr(ADR_CMP1, 32'(CP1));
    repeat (2 * PER) tick();
    rd(ADR_STAT, d);
    `CHK("sw left", 1'b0, d[STAT_SW])
    // Reset in mid-run drops every output at once
    rst_n_i <= 1'b0;
    tick();
    `CHK("pins mid reset", 9'h000, obs)
    tally_and_finish();
  end
endmodule : spdo_core_tb
`default_nettype wire
